/* design/nab_alu.sv */
// nab_alu: 4-bit binary/decimal alu with temporary registers, flags,
// write-back and skip decision, plus a plain register port for the flags.
// assumes operand data from the register file and data memory arrive on the
// core clock in the same cycle as the start strobe.
`timescale 1ns/100ps
module nab_alu #(
  parameter int NIB_W = nab_pkg::NIB_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // sequencer request
  input wire logic op_start,
  input wire nab_pkg::nab_op_t op_code,
  input wire nab_pkg::nab_form_t op_form,
  input wire logic [nab_pkg::RADDR_W-1:0] op_reg_addr,
  input wire logic [nab_pkg::MADDR_W-1:0] op_mem_addr,
  input wire logic [NIB_W-1:0] immediate_nibble,
  input wire logic op_mem_is_status,
  // operand data
  input wire logic [NIB_W-1:0] gen_reg_rdata,
  input wire logic [NIB_W-1:0] mem_rdata,
  // write-back and sequencer answer
  output logic wb_reg_we,
  output logic [nab_pkg::RADDR_W-1:0] wb_reg_addr,
  output logic wb_mem_we,
  output logic [nab_pkg::MADDR_W-1:0] wb_mem_addr,
  output logic [NIB_W-1:0] wb_data,
  output logic skip_next,
  output logic op_done,
  // flag view for the core
  output logic carry_flag,
  output logic zero_flag,
  output logic result_suppress_flag,
  output logic decimal_flag,
  // register port
  input wire logic [nab_pkg::BUS_AW-1:0] bus_addr,
  input wire logic [NIB_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [NIB_W-1:0] bus_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // decimal conversion of a 5-bit binary outcome {carry/borrow, nibble}
  function automatic logic [4:0] dec_fix(input logic [4:0] bin, input logic is_sub);
    logic [4:0] res;
    res = bin;
    if (!is_sub)
    begin
      if (bin < nab_pkg::DEC_TEN)
        res = bin;
      else if (bin < nab_pkg::DEC_TWENTY)
        res = {1'b1, 4'(bin - nab_pkg::DEC_TEN)};
      else
      begin
        // out of range sums map to fixed codes of 1010B or above
        unique case (bin[3:0])
          4'h4, 4'h8: res = 5'h1E;
          4'h5, 4'h9: res = 5'h1F;
          4'h6, 4'hA, 4'hE: res = 5'h1C;
          4'h7, 4'hB, 4'hF: res = 5'h1D;
          4'hC: res = 5'h1A;
          4'hD: res = 5'h1B;
          default: res = 5'h1E;
        endcase
      end
    end
    else
    begin
      if (bin < nab_pkg::DEC_TEN)
        res = bin;
      else if (!bin[4] || (bin < nab_pkg::DEC_NEG_TEN))
        res = {1'b1, 2'b11, bin[1:0] ^ 2'b10}; // code cycles 1100..1111 from ten upward
      else
        res = {1'b1, 4'(bin[3:0] + 4'hA)};
    end
    return res;
  endfunction : dec_fix

  // arithmetic opcode test, used by decode and flag logic
  function automatic logic is_arith(input nab_pkg::nab_op_t op);
    return (op == nab_pkg::OP_ADD) || (op == nab_pkg::OP_ADD_WITH_CARRY_OP) ||
           (op == nab_pkg::OP_SUB) || (op == nab_pkg::OP_SUB_WITH_BORROW_OP);
  endfunction : is_arith

  ////////////////////////////////////////////////////////////////////////////
  // state
  nab_pkg::nab_state_t state_r;
  nab_pkg::nab_op_t op_r;
  nab_pkg::nab_form_t form_r;
  logic [nab_pkg::RADDR_W-1:0] reg_addr_r;
  logic [nab_pkg::MADDR_W-1:0] mem_addr_r;
  logic dest_status_r;
  logic [NIB_W-1:0] temp_a_r;
  logic [NIB_W-1:0] temp_b_r;
  logic [NIB_W-1:0] status_word_r;
  logic [NIB_W-1:0] pointer_low_r;
  logic skip_r;

  ////////////////////////////////////////////////////////////////////////////
  // instruction sequencing: idle, execute, done pulse
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= nab_pkg::ST_IDLE;
    else if (ce)
    begin
      unique case (state_r)
        nab_pkg::ST_IDLE: if (op_start) state_r <= nab_pkg::ST_EXEC;
        nab_pkg::ST_EXEC: state_r <= nab_pkg::ST_DONE;
        nab_pkg::ST_DONE: state_r <= nab_pkg::ST_IDLE;
        default: state_r <= nab_pkg::ST_IDLE;
      endcase
    end
  end

  // operand latch into temporary A and B
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      temp_a_r <= '0;
      temp_b_r <= '0;
      op_r <= nab_pkg::OP_ADD;
      form_r <= nab_pkg::FORM_REG_MEM;
      reg_addr_r <= '0;
      mem_addr_r <= '0;
      dest_status_r <= 1'b0;
    end
    else if (ce && op_start && (state_r == nab_pkg::ST_IDLE))
    begin
      op_r <= op_code;
      form_r <= op_form;
      reg_addr_r <= op_reg_addr;
      mem_addr_r <= op_mem_addr;
      dest_status_r <= (op_form == nab_pkg::FORM_MEM_IMM) && op_mem_is_status;
      // in the memory-immediate form the status word is read from its own register, not from memory
      if ((op_code == nab_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP) || (op_form == nab_pkg::FORM_REG_MEM))
        temp_a_r <= gen_reg_rdata;
      else if (op_mem_is_status)
        temp_a_r <= status_word_r;
      else
        temp_a_r <= mem_rdata;
      if (op_form == nab_pkg::FORM_REG_MEM)
        temp_b_r <= mem_rdata;
      else
        temp_b_r <= immediate_nibble;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // combinational alu core
  logic cur_carry;
  logic cur_suppress;
  logic cur_decimal;
  logic use_carry;
  logic is_sub;
  logic [4:0] bin_res;
  logic [4:0] arith_res;
  logic [NIB_W-1:0] alu_out;
  logic [4:0] cmp_diff;
  logic skip_cond;

  assign cur_carry = status_word_r[nab_pkg::SW_CARRY_BIT];
  assign cur_suppress = status_word_r[nab_pkg::SW_SUPPRESS_BIT];
  assign cur_decimal = pointer_low_r[nab_pkg::PL_DECIMAL_BIT];

  // binary first, then optional decimal conversion
  always_comb
  begin
    use_carry = (op_r == nab_pkg::OP_ADD_WITH_CARRY_OP) || (op_r == nab_pkg::OP_SUB_WITH_BORROW_OP);
    is_sub = (op_r == nab_pkg::OP_SUB) || (op_r == nab_pkg::OP_SUB_WITH_BORROW_OP);
    if (is_sub)
      bin_res = 5'({1'b0, temp_a_r} - {1'b0, temp_b_r} - {4'h0, use_carry & cur_carry});
    else
      bin_res = 5'({1'b0, temp_a_r} + {1'b0, temp_b_r} + {4'h0, use_carry & cur_carry});
    if (cur_decimal)
      arith_res = dec_fix(bin_res, is_sub);
    else
      arith_res = bin_res;
  end

  // result nibble per instruction
  always_comb
  begin
    unique case (op_r)
      nab_pkg::OP_OR: alu_out = temp_a_r | temp_b_r;
      nab_pkg::OP_AND: alu_out = temp_a_r & temp_b_r;
      nab_pkg::OP_XOR: alu_out = temp_a_r ^ temp_b_r;
      nab_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP: alu_out = {cur_carry, temp_a_r[NIB_W-1:1]};
      default: alu_out = arith_res[NIB_W-1:0];
    endcase
  end

  // skip decision for tests and compares; compares always binary
  always_comb
  begin
    cmp_diff = 5'({1'b0, temp_a_r} - {1'b0, temp_b_r});
    unique case (op_r)
      nab_pkg::OP_SKT: skip_cond = ((temp_a_r & temp_b_r) == temp_b_r);
      nab_pkg::OP_SKF: skip_cond = ((temp_a_r & temp_b_r) == '0);
      nab_pkg::OP_SKE: skip_cond = (cmp_diff[3:0] == '0);
      nab_pkg::OP_SKNE: skip_cond = (cmp_diff[3:0] != '0);
      nab_pkg::OP_SKGE: skip_cond = !cmp_diff[4];
      nab_pkg::OP_SKLT: skip_cond = cmp_diff[4];
      default: skip_cond = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write-back strobes, one cycle in the done state
  logic exec_now;
  logic store_ok;
  logic writes_back;
  assign exec_now = ce && (state_r == nab_pkg::ST_EXEC);
  // logical and rotate always store; arithmetic only with suppression off
  assign store_ok = is_arith(op_r) ? !cur_suppress : 1'b1;
  assign writes_back = (is_arith(op_r) || (op_r == nab_pkg::OP_OR) || (op_r == nab_pkg::OP_AND) ||
                        (op_r == nab_pkg::OP_XOR) || (op_r == nab_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP)) && store_ok;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_reg_we <= 1'b0;
      wb_mem_we <= 1'b0;
      wb_reg_addr <= '0;
      wb_mem_addr <= '0;
      wb_data <= '0;
      op_done <= 1'b0;
    end
    else if (ce)
    begin
      op_done <= exec_now;
      wb_reg_we <= exec_now && writes_back &&
                   ((form_r == nab_pkg::FORM_REG_MEM) || (op_r == nab_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP));
      // status word destination is written internally, never to memory
      wb_mem_we <= exec_now && writes_back && (form_r == nab_pkg::FORM_MEM_IMM) &&
                   (op_r != nab_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP) && !dest_status_r;
      if (exec_now)
      begin
        wb_reg_addr <= reg_addr_r;
        wb_mem_addr <= mem_addr_r;
        wb_data <= alu_out;
      end
    end
  end

  // skip decision stands from done until the next instruction finishes
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      skip_r <= 1'b0;
    else if (exec_now)
      skip_r <= skip_cond;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word: alu update wins over a same-cycle register write
  logic zero_res;
  assign zero_res = (alu_out == '0);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      status_word_r <= nab_pkg::STATUS_WORD_RST;
    else if (ce)
    begin
      if (exec_now && is_arith(op_r))
      begin
        if (!cur_suppress && dest_status_r)
          status_word_r <= alu_out;
        else
        begin
          status_word_r[nab_pkg::SW_CARRY_BIT] <= arith_res[4];
          if (!cur_suppress)
            status_word_r[nab_pkg::SW_ZERO_BIT] <= zero_res;
          else if (!zero_res)
            status_word_r[nab_pkg::SW_ZERO_BIT] <= 1'b0;
        end
      end
      else if (exec_now && (op_r == nab_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP))
        status_word_r[nab_pkg::SW_CARRY_BIT] <= temp_a_r[0];
      else if (exec_now && dest_status_r && writes_back)
        status_word_r <= alu_out; // logical result lands in the status word itself
      else if (exec_now && ((op_r == nab_pkg::OP_SKT) || (op_r == nab_pkg::OP_SKF)))
        status_word_r[nab_pkg::SW_SUPPRESS_BIT] <= 1'b0;
      else if (exec_now)
        status_word_r <= status_word_r; // logical and compare keep all flags
      else if (bus_wr && (bus_addr == nab_pkg::REG_STATUS_WORD))
        status_word_r <= bus_wdata;
    end
  end

  // pointer low nibble holds the decimal mode select
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pointer_low_r <= nab_pkg::POINTER_LOW_RST;
    else if (ce && bus_wr && (bus_addr == nab_pkg::REG_POINTER_LOW))
      pointer_low_r <= bus_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_rdata <= '0;
    else if (ce)
    begin
      bus_rdata <= '0;
      if (bus_rd)
      begin
        unique case (bus_addr)
          nab_pkg::REG_STATUS_WORD: bus_rdata <= status_word_r;
          nab_pkg::REG_POINTER_LOW: bus_rdata <= pointer_low_r;
          nab_pkg::REG_ALU_STATE:
          begin
            bus_rdata[nab_pkg::AS_SKIP_BIT] <= skip_r;
            bus_rdata[nab_pkg::AS_BUSY_BIT] <= (state_r != nab_pkg::ST_IDLE);
          end
          default: bus_rdata <= '0;
        endcase
      end
    end
  end

  // registered flag view; copies lag the status register by one cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      result_suppress_flag <= 1'b0;
      decimal_flag <= 1'b0;
      skip_next <= 1'b0;
    end
    else if (ce)
    begin
      carry_flag <= status_word_r[nab_pkg::SW_CARRY_BIT];
      zero_flag <= status_word_r[nab_pkg::SW_ZERO_BIT];
      result_suppress_flag <= status_word_r[nab_pkg::SW_SUPPRESS_BIT];
      decimal_flag <= pointer_low_r[nab_pkg::PL_DECIMAL_BIT];
      if (exec_now)
        skip_next <= skip_cond;
    end
  end

endmodule : nab_alu

/* design/nab_pkg.sv */
// nab_pkg: shared constants and types of the nibble alu datapath.
// assumes a single core clock; all users write nab_pkg::name, nothing imported.
package nab_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int NIB_W = 4;
  localparam int RADDR_W = 4;
  localparam int MADDR_W = 4;
  localparam int BUS_AW = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register port map (word index on the plain register port)
  localparam logic [3:0] REG_STATUS_WORD = 4'h0;
  localparam logic [3:0] REG_POINTER_LOW = 4'h1;
  localparam logic [3:0] REG_ALU_STATE = 4'h2;

  // status word nibble layout
  localparam int SW_SUPPRESS_BIT = 3;
  localparam int SW_CARRY_BIT = 2;
  localparam int SW_ZERO_BIT = 1;

  // pointer low nibble layout: bit 0 selects decimal arithmetic
  localparam int PL_DECIMAL_BIT = 0;

  // alu state register layout
  localparam int AS_SKIP_BIT = 0;
  localparam int AS_BUSY_BIT = 1;

  // reset values
  localparam logic [3:0] STATUS_WORD_RST = 4'h0;
  localparam logic [3:0] POINTER_LOW_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // decimal conversion constants
  localparam logic [4:0] DEC_TEN = 5'h0A;
  localparam logic [4:0] DEC_TWENTY = 5'h14;
  localparam logic [4:0] DEC_NEG_TEN = 5'h16; // -10 as borrow,nibble

  ////////////////////////////////////////////////////////////////////////////
  // instruction codes handed over by the sequencer
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADD_WITH_CARRY_OP = 4'h1,
    OP_SUB = 4'h2,
    OP_SUB_WITH_BORROW_OP = 4'h3,
    OP_OR = 4'h4,
    OP_AND = 4'h5,
    OP_XOR = 4'h6,
    OP_SKT = 4'h7,
    OP_SKF = 4'h8,
    OP_SKE = 4'h9,
    OP_SKNE = 4'hA,
    OP_SKGE = 4'hB,
    OP_SKLT = 4'hC,
    OP_ROTATE_RIGHT_THROUGH_CARRY_OP = 4'hD
  } nab_op_t;

  // operand form: general register with memory, or memory with immediate
  typedef enum logic {
    FORM_REG_MEM = 1'b0,
    FORM_MEM_IMM = 1'b1
  } nab_form_t;

  // sequencing of one instruction
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b10
  } nab_state_t;

endpackage : nab_pkg

/* bench/nab_alu_checker.sv */
// nab_alu_checker: concurrent checks on the ports of the nibble alu.
// assumes one core clock, async active-low reset and ce held high.
`timescale 1ns/100ps
module nab_alu_checker #(
  parameter int NIB_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // sequencer request and register operand
  input wire logic op_start,
  input wire nab_pkg::nab_op_t op_code,
  input wire nab_pkg::nab_form_t op_form,
  input wire logic op_mem_is_status,
  input wire logic [NIB_W-1:0] gen_reg_rdata,
  // answer and flags
  input wire logic wb_reg_we,
  input wire logic wb_mem_we,
  input wire logic [NIB_W-1:0] wb_data,
  input wire logic op_done,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic result_suppress_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////
  // cycles left of an accepted instruction; starts while busy are dropped
  logic [1:0] pend_r;
  logic [1:0] pend_nxt;
  assign pend_nxt = (pend_r != 2'h0) ? pend_r - 2'h1 : (op_start ? 2'h2 : 2'h0);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pend_r <= 2'h0;
    else
      pend_r <= pend_nxt;
  end

  // instruction class of the request being taken
  wire logic go = op_start && pend_r == 2'h0;
  wire logic is_arith = op_code <= nab_pkg::OP_SUB_WITH_BORROW_OP;
  wire logic is_logic = op_code inside {nab_pkg::OP_OR, nab_pkg::OP_AND, nab_pkg::OP_XOR};
  wire logic is_bit = op_code inside {nab_pkg::OP_SKT, nab_pkg::OP_SKF};
  wire logic is_test = op_code inside {[nab_pkg::OP_SKT:nab_pkg::OP_SKLT]};
  wire logic is_rot = op_code == nab_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP;
  wire logic stores = !op_mem_is_status && (is_logic || is_arith && !result_suppress_flag);

  ////////////////////////////////////////
  done_timing_a: assert property (go |-> ##2 op_done)
    else $error("done not two cycles after start");
  done_cause_a: assert property (op_done |-> $past(op_start, 2))
    else $error("done without a start");
  strobe_done_a: assert property ((wb_reg_we || wb_mem_we) |-> op_done)
    else $error("write strobe outside done");
  test_no_store_a: assert property (go && is_test |-> ##2 !wb_reg_we && !wb_mem_we)
    else $error("test instruction wrote back");
  suppress_no_store_a: assert property (go && is_arith && result_suppress_flag |-> ##2 !wb_reg_we && !wb_mem_we)
    else $error("suppressed result written");
  store_dest_a: assert property (go && stores |-> ##2 (wb_reg_we != wb_mem_we)
    && (wb_mem_we == ($past(op_form, 2) == nab_pkg::FORM_MEM_IMM)))
    else $error("write-back to wrong place");
  logic_flags_a: assert property (go && is_logic && !op_mem_is_status |-> ##3 carry_flag == $past(carry_flag, 3)
    && zero_flag == $past(zero_flag, 3))
    else $error("logical op moved a flag");
  bit_clear_a: assert property (go && is_bit |-> ##3 !result_suppress_flag)
    else $error("bit test left suppress set");
  rotate_data_a: assert property (go && is_rot |-> ##2 wb_reg_we
    && wb_data == {$past(carry_flag, 2), $past(gen_reg_rdata[3:1], 2)})
    else $error("rotate data wrong");
  rotate_carry_a: assert property (go && is_rot |-> ##3 carry_flag == $past(gen_reg_rdata[0], 3))
    else $error("rotate carry wrong");

  // main scenarios reached
  cover property (go && is_logic);
  cover property (go && is_arith && result_suppress_flag);
  cover property (go && is_bit);
  cover property (go && is_rot);
endmodule : nab_alu_checker

bind nab_alu nab_alu_checker #(.NIB_W(NIB_W)) chk (
  .clk(clk), .resetn(resetn), .op_start(op_start), .op_code(op_code), .op_form(op_form),
  .op_mem_is_status(op_mem_is_status), .gen_reg_rdata(gen_reg_rdata), .wb_reg_we(wb_reg_we),
  .wb_mem_we(wb_mem_we), .wb_data(wb_data), .op_done(op_done), .carry_flag(carry_flag),
  .zero_flag(zero_flag), .result_suppress_flag(result_suppress_flag)
);

/* bench/nab_core_model.sv */
// nab_core_model: general registers and data memory beside the alu.
// assumes write strobes are one-cycle pulses on the core clock.
`timescale 1ns/100ps
module nab_core_model (
  // clock
  input wire logic clk,
  // operand addresses
  input wire logic [3:0] op_reg_addr,
  input wire logic [3:0] op_mem_addr,
  // write-back
  input wire logic wb_reg_we,
  input wire logic [3:0] wb_reg_addr,
  input wire logic wb_mem_we,
  input wire logic [3:0] wb_mem_addr,
  input wire logic [3:0] wb_data,
  // operand data
  output logic [3:0] gen_reg_rdata,
  output logic [3:0] mem_rdata
);
  logic [3:0] regs [16];
  logic [3:0] mem [16];
  // reads follow the address so operands stand in the start cycle
  assign gen_reg_rdata = regs[op_reg_addr];
  assign mem_rdata = mem[op_mem_addr];
  // store whatever the alu writes back; no check here, the bench judges it
  always @(posedge clk)
  begin
    if (wb_reg_we)
      regs[wb_reg_addr] <= wb_data;
    if (wb_mem_we)
      mem[wb_mem_addr] <= wb_data;
  end
endmodule : nab_core_model

/* bench/nab_alu_test.sv */
// nab_alu_test: self-checking bench for the nibble alu and its core model.
// assumes a two-cycle answer and a flag view that lags the status word by one.
`timescale 1ns/100ps
module nab_alu_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic op_start = 1'b0;
  nab_pkg::nab_op_t op_code = nab_pkg::OP_ADD;
  nab_pkg::nab_form_t op_form = nab_pkg::FORM_REG_MEM;
  logic [3:0] op_reg_addr = 4'h0;
  logic [3:0] op_mem_addr = 4'h0;
  logic [3:0] immediate_nibble = 4'h0;
  logic op_mem_is_status = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [3:0] bus_wdata = 4'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [3:0] gen_reg_rdata, mem_rdata, wb_data, wb_reg_addr, wb_mem_addr, bus_rdata;
  logic wb_reg_we, wb_mem_we, skip_next, op_done, carry_flag, zero_flag, result_suppress_flag, decimal_flag;
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] seed = 32'hD4E5F92D;

  always #25 clk = ~clk;

  nab_alu uut (.clk(clk), .resetn(resetn), .ce(1'b1), .op_start(op_start), .op_code(op_code),
    .op_form(op_form), .op_reg_addr(op_reg_addr), .op_mem_addr(op_mem_addr),
    .immediate_nibble(immediate_nibble), .op_mem_is_status(op_mem_is_status),
    .gen_reg_rdata(gen_reg_rdata), .mem_rdata(mem_rdata), .wb_reg_we(wb_reg_we),
    .wb_reg_addr(wb_reg_addr), .wb_mem_we(wb_mem_we), .wb_mem_addr(wb_mem_addr), .wb_data(wb_data),
    .skip_next(skip_next), .op_done(op_done), .carry_flag(carry_flag), .zero_flag(zero_flag),
    .result_suppress_flag(result_suppress_flag), .decimal_flag(decimal_flag), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  nab_core_model core (.clk(clk), .op_reg_addr(op_reg_addr), .op_mem_addr(op_mem_addr),
    .wb_reg_we(wb_reg_we), .wb_reg_addr(wb_reg_addr), .wb_mem_we(wb_mem_we),
    .wb_mem_addr(wb_mem_addr), .wb_data(wb_data), .gen_reg_rdata(gen_reg_rdata), .mem_rdata(mem_rdata));

  ////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xorshift

  task automatic rnd(output logic [3:0] v);
    seed = xorshift(seed);
    v = seed[7:4];
  endtask : rnd

  // binary raw {carry, nibble} into the decimal digit; out-of-range codes are fixed
  function automatic logic [4:0] dec_adj(input logic [4:0] raw, input logic sub);
    if (raw < 5'h0A)
      return raw;
    if (sub && raw >= 5'h16)
      return {1'b1, raw[3:0] + 4'hA};
    if (!sub && raw < 5'h14)
      return {1'b1, 4'(raw - 5'h0A)};
    if (!sub && raw >= 5'h1C)
      return {1'b1, 4'(raw - 5'h12)};
    return {3'b111, raw[1:0] ^ 2'h2};
  endfunction : dec_adj

  task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // strobes drop one edge before the next request so no signal moves twice at once
  task automatic bus_write(input logic [3:0] a, input logic [3:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [3:0] d);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    d = bus_rdata;
    @(posedge clk);
  endtask : bus_read

  ////////////////////////////////////////
  // one instruction on random operands with a preset status word and mode
  task automatic run(input logic [3:0] opc, input logic frm, input logic [3:0] sw, input logic dec, input logic ms);
    logic [3:0] ra, ma, im, rv, mv, a, b, r, rd;
    logic [4:0] raw;
    logic c, z, s, sk, st;
    rnd(ra);
    rnd(ma);
    rnd(im);
    rnd(rv);
    rnd(mv);
    core.regs[ra] = rv;
    core.mem[ma] = mv;
    bus_write(nab_pkg::REG_POINTER_LOW, {3'h0, dec});
    bus_write(nab_pkg::REG_STATUS_WORD, sw);
    a = ms ? sw : (frm ? mv : rv);
    b = frm ? im : mv;
    {s, c, z} = sw[3:1];
    sk = 1'b0;
    st = 1'b1;
    r = a;
    raw = opc[1] ? {1'b0, a} - {1'b0, b} - (opc[0] & c) : {1'b0, a} + {1'b0, b} + (opc[0] & c);
    if (dec)
      raw = dec_adj(raw, opc[1]);
    case (opc)
      4'h0, 4'h1, 4'h2, 4'h3:
      begin
        {c, r} = raw;
        z = (r == 4'h0) && (z || !s);
        st = !s;
      end
      4'h4: r = a | b;
      4'h5: r = a & b;
      4'h6: r = a ^ b;
      4'hD:
      begin
        r = {c, a[3:1]};
        c = a[0];
      end
      default:
      begin
        st = 1'b0;
        s = (opc < 4'h9) ? 1'b0 : s;
        sk = opc == 4'h7 ? (a & b) == b : opc == 4'h8 ? (a & b) == 4'h0 : opc == 4'h9 ? a == b
          : opc == 4'hA ? a != b : opc == 4'hB ? a >= b : a < b;
      end
    endcase
    // a stored result aimed at the status word replaces its flags
    if (ms && st)
      {s, c, z} = r[3:1];
    op_code <= nab_pkg::nab_op_t'(opc);
    op_form <= nab_pkg::nab_form_t'(frm);
    op_reg_addr <= ra;
    op_mem_addr <= ma;
    immediate_nibble <= im;
    op_mem_is_status <= ms;
    op_start <= 1'b1;
    @(posedge clk);
    op_start <= 1'b0;
    for (int i = 0; i < 6 && op_done !== 1'b1; i++)
      @(negedge clk);
    check("done", op_done, 1'b1);
    if (opc >= 4'h7 && opc <= 4'hC)
      check("skip", skip_next, sk);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("carry", carry_flag, c);
    check("zero", zero_flag, z);
    check("suppress", result_suppress_flag, s);
    check("decimal", decimal_flag, dec);
    check("register", core.regs[ra], (st && !frm) ? r : rv);
    check("memory", core.mem[ma], (st && frm && !ms) ? r : mv);
    @(posedge clk);
    bus_read(nab_pkg::REG_STATUS_WORD, rd);
    check("status", rd, {s, c, z, (ms && st) ? r[0] : sw[0]});
    bus_read(nab_pkg::REG_ALU_STATE, rd);
    check("alu state", rd, {3'h0, sk});
  endtask : run

  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // hang guard, well beyond the few thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    logic [3:0] o, f, w, d, rd;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    // sum into the status word itself, storing, then a suppressed subtract into it
    run(4'h0, 1'b1, 4'h4, 1'b0, 1'b1);
    run(4'h2, 1'b1, 4'hA, 1'b0, 1'b1);
    // logical result into the status word, then a decimal subtract on random memory and immediate operands
    run(4'h6, 1'b1, 4'h5, 1'b0, 1'b1);
    run(4'h2, 1'b1, 4'h0, 1'b1, 1'b0);
    // random codes, forms, flags and modes; tests force the memory form
    for (int i = 0; i < 300; i++)
    begin
      rnd(o);
      rnd(f);
      rnd(w);
      rnd(d);
      o = (o > 4'hD) ? o - 4'h8 : o;
      run(o, (o > 4'h6 && o < 4'hD) ? 1'b1 : (o == 4'hD ? 1'b0 : f[0]), w, d[0], 1'b0);
    end
    // reset in mid-run: registers and flag view fall back to reset values
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    bus_read(nab_pkg::REG_POINTER_LOW, rd);
    check("pointer reset", rd, nab_pkg::POINTER_LOW_RST);
    bus_read(nab_pkg::REG_STATUS_WORD, rd);
    check("status reset", rd, nab_pkg::STATUS_WORD_RST);
    check("carry reset", carry_flag, 1'b0);
    // unmapped address: writes vanish, reads give zero
    bus_write(4'h7, 4'hF);
    bus_read(4'h7, rd);
    check("unmapped", rd, 4'h0);
    print_verdict();
  end
endmodule : nab_alu_test
